// [verilog/rsc_reset_ctrl.sv]
// Reset sources, start-up sequencer and reset cause flags
//
// Notes on behaviour
// - Mode 01: software bit gates brown-out detection
// - Fast start forces band gap in modes 10/01
// - Brown-out control bit 0 shows circuit ready
// - Low-power detector resets, clears brown-out flag
// - Low-power detector enabled only by fuse
// - Pin reset off only if both fuses 0
// - Pin held low holds reset; glitches filtered
// - Reset logic never drives the pin
// - Pin disabled: general input, software pull-up
// - Watchdog time-out resets, updates time-out flags
// - Reset instruction resets, clears its flag
// - Stack over/underflow resets when enabled, sets flag
// - Programming exit behaves as power-on reset
// - Start waits for timer and pin release
// - Timer independent; run 10 cycles after release
// - Power-on: PC 0, status 11, flags 00110x
// - Brown-out: PC 0, status 11, flags 0011u0
// - Pin reset clears flag; sleep also TO1 PD0
// - Watchdog reset/wake flags and PC
// - Interrupt wake: PD0, vector 0004h if enabled
// - Power-up timer holds 64 ms after release
// - Hardware clears cause flags and sets stack flags; software writes them back
`timescale 1ns/10ps
`include "rsc_regs.svh"

module rsc_reset_ctrl #(
	parameter int unsigned POWERUP_TIMER_CYCLES = `RSC_POWERUP_TIMER_CYC
) (
	input  wire logic                    clk_sys_i,
	input  wire logic                    reset_n_i,
	input  wire logic [`RSC_ADDR_W-1:0]  reg_addr_i,
	input  wire logic [`RSC_DATA_W-1:0]  reg_wdata_i,
	input  wire logic                    reg_wr_i,
	input  wire logic                    reg_rd_i,
	output logic      [`RSC_DATA_W-1:0]  reg_rdata_o,
	input  wire logic [1:0]              brownout_mode_cfg_i,
	input  wire logic                    low_power_brownout_fuse_i,
	input  wire logic                    master_clear_pin_enable_i,
	input  wire logic                    low_voltage_programming_i,
	input  wire logic                    powerup_timer_enable_n_i,
	input  wire logic                    stack_reset_enable_i,
	input  wire logic                    brownout_ready_i,
	input  wire logic                    brownout_low_i,
	input  wire logic                    lp_brownout_low_i,
	input  wire logic                    master_clear_pin_i,
	input  wire logic                    pullup_sw_i,
	output logic                         master_clear_pin_o,
	output logic                         master_clear_pin_oe_o,
	output logic                         gp_input_o,
	output logic                         weak_pullup_en_o,
	input  wire logic                    sleep_i,
	input  wire logic                    watchdog_timeout_i,
	input  wire logic                    reset_instr_i,
	input  wire logic                    stack_overflow_i,
	input  wire logic                    stack_underflow_i,
	input  wire logic                    prog_mode_i,
	input  wire logic                    irq_wake_i,
	input  wire logic                    global_irq_enable_i,
	input  wire logic [`RSC_PC_W-1:0]    pc_i,
	output logic                         device_reset_o,
	output logic                         brownout_detect_en_o,
	output logic                         bandgap_force_on_o,
	output logic                         pc_load_o,
	output logic      [`RSC_PC_W-1:0]    pc_value_o,
	output logic                         push_return_o
);

	localparam logic [`RSC_CNT_W-1:0] POWERUP_TIMER_LAST =
		`RSC_CNT_W'(POWERUP_TIMER_CYCLES - 1);
	localparam logic [`RSC_CNT_W-1:0] DLY_LAST =
		`RSC_CNT_W'(`RSC_START_DLY_CYC - 1);

	function automatic logic bor_active(input logic [1:0] mode,
		input logic sleep, input logic sw_en);
		case (mode)
			`RSC_MODE_ON:      bor_active = 1'b1;
			`RSC_MODE_NOSLEEP: bor_active = !sleep;
			`RSC_MODE_SW:      bor_active = sw_en;
			default:           bor_active = 1'b0;
		endcase
	endfunction

	rsc_pkg::rsc_state_t      state;
	rsc_pkg::rsc_state_t      next_state;
	logic [`RSC_CNT_W-1:0]    cnt;
	logic [`RSC_CNT_W-1:0]    next_cnt;
	logic                     seen;
	logic                     next_seen;
	logic [2:0]               filt_cnt;
	logic                     sw_bor;
	logic                     bor_fs;
	logic                     bor_rdy;
	logic [`RSC_DATA_W-1:0]   reset_cause_reg;
	logic [`RSC_DATA_W-1:0]   next_reset_cause_reg;
	logic                     to_n;
	logic                     next_to_n;
	logic                     pd_n;
	logic                     next_pd_n;
	logic                     prog_q;
	logic                     vec_pend;

	wire run        = (state == rsc_pkg::ST_RUN);
	wire master_clear_pin_en    = master_clear_pin_enable_i | low_voltage_programming_i;
	wire master_clear_pin_held  = (filt_cnt == `RSC_FILT_CYC);
	wire master_clear_pin_stall = master_clear_pin_en & master_clear_pin_held;
	wire master_clear_pin_start = run & master_clear_pin_stall;
	wire bor_en     = bor_active(brownout_mode_cfg_i, sleep_i, sw_bor);
	wire bor_trip   = bor_en & bor_rdy & brownout_low_i;
	// An erased fuse reads 1, which leaves the low-power detector off
	wire lp_trip    = !low_power_brownout_fuse_i & lp_brownout_low_i;
	wire brown_evt  = bor_trip | lp_trip;
	wire prog_exit  = prog_q & !prog_mode_i;
	wire hold_power = brown_evt | prog_mode_i;
	wire bor_wait   = brownout_mode_cfg_i[1] & !bor_rdy;
	wire wdt_rst    = run & watchdog_timeout_i & !sleep_i;
	wire wdt_wake   = run & watchdog_timeout_i & sleep_i;
	wire irq_wake   = run & irq_wake_i & sleep_i;
	wire instr_rst  = run & reset_instr_i;
	wire ovf_rst    = run & stack_reset_enable_i & stack_overflow_i;
	wire unf_rst    = run & stack_reset_enable_i & stack_underflow_i;
	wire soft_rst   = wdt_rst | instr_rst | ovf_rst | unf_rst;
	wire fs_live    = (brownout_mode_cfg_i == `RSC_MODE_NOSLEEP) |
		(brownout_mode_cfg_i == `RSC_MODE_SW);
	wire wr_brownout_control  = reg_wr_i & (reg_addr_i == `RSC_ADDR_BROWNOUT_CONTROL);
	wire wr_reset_cause_reg    = reg_wr_i & (reg_addr_i == `RSC_ADDR_RESET_CAUSE_REG);
	wire enter_run  = !run & (next_state == rsc_pkg::ST_RUN);
	wire wake_load  = !soft_rst & !master_clear_pin_stall & (wdt_wake | irq_wake);
	wire [`RSC_PC_W-1:0] pc_next = `RSC_PC_W'(pc_i + 1'b1);

	wire [`RSC_DATA_W-1:0] brownout_control_rd = {sw_bor, bor_fs, 5'h00, bor_rdy};
	wire [`RSC_DATA_W-1:0] status_rd = {3'h0, to_n, pd_n, 3'h0};
	wire [`RSC_DATA_W-1:0] rd_mux =
		(reg_addr_i == `RSC_ADDR_BROWNOUT_CONTROL) ? brownout_control_rd :
		(reg_addr_i == `RSC_ADDR_RESET_CAUSE_REG)   ? reset_cause_reg :
		(reg_addr_i == `RSC_ADDR_STATUS) ? status_rd : 8'h00;

	// Start-up and reset sequencing
	always_comb begin
		next_state = state;
		next_cnt = cnt;
		next_seen = seen;
		case (state)
			rsc_pkg::ST_HOLD: begin
				if (!(hold_power | bor_wait)) begin
					next_cnt = '0;
					next_state = powerup_timer_enable_n_i ?
						rsc_pkg::ST_MASTER_CLEAR_PIN_WAIT : rsc_pkg::ST_POWERUP_TIMER;
				end
			end
			rsc_pkg::ST_POWERUP_TIMER: begin
				// Pin is ignored here so the timer runs on its own
				if (cnt == POWERUP_TIMER_LAST)
					next_state = rsc_pkg::ST_MASTER_CLEAR_PIN_WAIT;
				else
					next_cnt = cnt + 1'b1;
			end
			rsc_pkg::ST_MASTER_CLEAR_PIN_WAIT: begin
				if (master_clear_pin_stall) begin
					next_seen = 1'b1;
				end else if (seen) begin
					next_state = rsc_pkg::ST_START_DLY;
					next_cnt = '0;
				end else begin
					next_state = rsc_pkg::ST_RUN;
				end
			end
			rsc_pkg::ST_START_DLY: begin
				if (cnt == DLY_LAST) begin
					next_state = rsc_pkg::ST_RUN;
					next_seen = 1'b0;
				end else begin
					next_cnt = cnt + 1'b1;
				end
			end
			rsc_pkg::ST_RUN: begin
				if (master_clear_pin_stall) begin
					next_state = rsc_pkg::ST_MASTER_CLEAR_PIN_WAIT;
					next_seen = 1'b1;
				end else if (soft_rst) begin
					next_state = rsc_pkg::ST_MASTER_CLEAR_PIN_WAIT;
					next_seen = 1'b0;
				end
			end
			default: begin
				next_state = rsc_pkg::ST_HOLD;
			end
		endcase
		if (hold_power) begin
			next_state = rsc_pkg::ST_HOLD;
			next_seen = 1'b0;
		end
	end

	// Cause flags: software write first, hardware events override it
	always_comb begin
		next_reset_cause_reg = reset_cause_reg;
		next_to_n = to_n;
		next_pd_n = pd_n;
		if (wr_reset_cause_reg)
			next_reset_cause_reg = reg_wdata_i & `RSC_RESET_CAUSE_REG_MASK;
		if (master_clear_pin_start) begin
			next_reset_cause_reg[`RSC_RESET_CAUSE_REG_PIN] = 1'b0;
			if (sleep_i) begin
				next_to_n = 1'b1;
				next_pd_n = 1'b0;
			end
		end
		if (wdt_rst) begin
			next_reset_cause_reg[`RSC_RESET_CAUSE_REG_WDT] = 1'b0;
			next_to_n = 1'b0;
		end
		if (wdt_wake) begin
			next_to_n = 1'b0;
			next_pd_n = 1'b0;
		end
		if (irq_wake) begin
			next_to_n = 1'b1;
			next_pd_n = 1'b0;
		end
		if (instr_rst)
			next_reset_cause_reg[`RSC_RESET_CAUSE_REG_INSTR] = 1'b0;
		if (ovf_rst)
			next_reset_cause_reg[`RSC_RESET_CAUSE_REG_OVF] = 1'b1;
		if (unf_rst)
			next_reset_cause_reg[`RSC_RESET_CAUSE_REG_UNF] = 1'b1;
		if (brown_evt) begin
			next_reset_cause_reg = {2'b00, 1'b0, reset_cause_reg[`RSC_RESET_CAUSE_REG_WDT], 2'b11,
				reset_cause_reg[`RSC_RESET_CAUSE_REG_POR], 1'b0};
			next_to_n = 1'b1;
			next_pd_n = 1'b1;
		end
		if (prog_exit) begin
			next_reset_cause_reg = `RSC_RESET_CAUSE_REG_POR_VAL;
			next_to_n = 1'b1;
			next_pd_n = 1'b1;
		end
	end

	always_ff @(posedge clk_sys_i) begin
		if (!reset_n_i) begin
			state <= rsc_pkg::ST_HOLD;
			cnt <= '0;
			seen <= 1'b0;
			prog_q <= 1'b0;
			filt_cnt <= 3'h0;
		end else begin
			state <= next_state;
			cnt <= next_cnt;
			seen <= next_seen;
			prog_q <= prog_mode_i;
			// Counts consecutive low samples; short pulses never reach the top
			if (master_clear_pin_i)
				filt_cnt <= 3'h0;
			else if (!master_clear_pin_held)
				filt_cnt <= filt_cnt + 3'h1;
		end
	end

	always_ff @(posedge clk_sys_i) begin
		if (!reset_n_i) begin
			reset_cause_reg <= `RSC_RESET_CAUSE_REG_POR_VAL;
			to_n <= 1'b1;
			pd_n <= 1'b1;
		end else begin
			reset_cause_reg <= next_reset_cause_reg;
			to_n <= next_to_n;
			pd_n <= next_pd_n;
		end
	end

	always_ff @(posedge clk_sys_i) begin
		if (!reset_n_i) begin
			sw_bor <= `RSC_BROWNOUT_CONTROL_SWEN_RST;
			bor_fs <= `RSC_BROWNOUT_CONTROL_FS_RST;
		end else if (brown_evt | prog_exit) begin
			sw_bor <= `RSC_BROWNOUT_CONTROL_SWEN_RST;
			bor_fs <= `RSC_BROWNOUT_CONTROL_FS_RST;
		end else if (wr_brownout_control) begin
			sw_bor <= reg_wdata_i[`RSC_BROWNOUT_CONTROL_SWEN];
			bor_fs <= reg_wdata_i[`RSC_BROWNOUT_CONTROL_FS];
		end
	end

	always_ff @(posedge clk_sys_i) begin
		if (!reset_n_i) begin
			bor_rdy <= 1'b0;
			brownout_detect_en_o <= 1'b0;
			bandgap_force_on_o <= 1'b0;
			reg_rdata_o <= 8'h00;
			device_reset_o <= 1'b1;
			master_clear_pin_o <= 1'b0;
			master_clear_pin_oe_o <= 1'b0;
			gp_input_o <= 1'b0;
			weak_pullup_en_o <= 1'b1;
		end else begin
			bor_rdy <= bor_en & brownout_ready_i;
			brownout_detect_en_o <= bor_en;
			bandgap_force_on_o <= fs_live & bor_fs;
			reg_rdata_o <= reg_rd_i ? rd_mux : 8'h00;
			device_reset_o <= (next_state != rsc_pkg::ST_RUN);
			// The pin is sense-only: no reset source ever pulls it low
			master_clear_pin_o <= 1'b0;
			master_clear_pin_oe_o <= 1'b0;
			gp_input_o <= master_clear_pin_en ? 1'b0 : master_clear_pin_i;
			weak_pullup_en_o <= master_clear_pin_en | pullup_sw_i;
		end
	end

	// Program counter after reset or wake-up
	always_ff @(posedge clk_sys_i) begin
		if (!reset_n_i) begin
			pc_load_o <= 1'b0;
			pc_value_o <= `RSC_VEC_RESET;
			vec_pend <= 1'b0;
			push_return_o <= 1'b0;
		end else begin
			pc_load_o <= enter_run | wake_load | vec_pend;
			if (enter_run)
				pc_value_o <= `RSC_VEC_RESET;
			else if (vec_pend)
				pc_value_o <= `RSC_VEC_IRQ;
			else if (wake_load)
				pc_value_o <= pc_next;
			vec_pend <= wake_load & irq_wake & global_irq_enable_i;
			push_return_o <= vec_pend;
		end
	end

	sequence s_irq_wake;
		irq_wake && wake_load && global_irq_enable_i;
	endsequence

	sequence s_vector_jump;
		pc_load_o && (pc_value_o == $past(pc_next)) ##1
		pc_load_o && push_return_o && (pc_value_o == `RSC_VEC_IRQ);
	endsequence

	sequence s_release_low;
		(state == rsc_pkg::ST_MASTER_CLEAR_PIN_WAIT) && seen && !master_clear_pin_stall &&
		!hold_power;
	endsequence

	AST_SW_BOR_EN: assert property (@(posedge clk_sys_i)
		disable iff (!reset_n_i)
		(brownout_mode_cfg_i == `RSC_MODE_SW) |=>
		(brownout_detect_en_o == $past(sw_bor)))
		else $error("software brown-out enable not followed");

	AST_BANDGAP_IDLE: assert property (@(posedge clk_sys_i)
		disable iff (!reset_n_i)
		!fs_live |=> !bandgap_force_on_o)
		else $error("band gap forced in a mode that ignores it");

	AST_READY_READ: assert property (@(posedge clk_sys_i)
		disable iff (!reset_n_i)
		(reg_rd_i && reg_addr_i == `RSC_ADDR_BROWNOUT_CONTROL) |=>
		(reg_rdata_o[`RSC_BROWNOUT_CONTROL_RDY] == $past(bor_rdy)))
		else $error("ready bit read back wrong");

	AST_LP_TRIP: assert property (@(posedge clk_sys_i)
		disable iff (!reset_n_i)
		(lp_trip && !prog_exit) |=>
		device_reset_o && !reset_cause_reg[`RSC_RESET_CAUSE_REG_BOR] && to_n && pd_n)
		else $error("low-power brown-out did not reset and flag");

	AST_PIN_FILTER: assert property (@(posedge clk_sys_i)
		disable iff (!reset_n_i)
		master_clear_pin_held |-> !$past(master_clear_pin_i, 1) &&
		!$past(master_clear_pin_i, 2) && !$past(master_clear_pin_i, 3) &&
		!$past(master_clear_pin_i, 4))
		else $error("pin reset taken on a short pulse");

	AST_PIN_UNDRIVEN: assert property (@(posedge clk_sys_i)
		disable iff (!reset_n_i)
		!master_clear_pin_oe_o && !master_clear_pin_o)
		else $error("reset logic drives the pin");

	AST_WDT_RESET: assert property (@(posedge clk_sys_i)
		disable iff (!reset_n_i)
		(wdt_rst && !hold_power && !prog_exit) |=>
		!to_n && !reset_cause_reg[`RSC_RESET_CAUSE_REG_WDT] && device_reset_o)
		else $error("watchdog reset flags wrong");

	AST_INSTR_RESET: assert property (@(posedge clk_sys_i)
		disable iff (!reset_n_i)
		(instr_rst && !hold_power && !prog_exit) |=>
		!reset_cause_reg[`RSC_RESET_CAUSE_REG_INSTR] && device_reset_o)
		else $error("reset instruction not handled");

	AST_STACK_FLAG: assert property (@(posedge clk_sys_i)
		disable iff (!reset_n_i)
		(ovf_rst && !brown_evt && !prog_exit) |=> reset_cause_reg[`RSC_RESET_CAUSE_REG_OVF])
		else $error("stack overflow flag not set");

	AST_PROG_EXIT: assert property (@(posedge clk_sys_i)
		disable iff (!reset_n_i)
		prog_exit |=> (reset_cause_reg == `RSC_RESET_CAUSE_REG_POR_VAL) && to_n && pd_n &&
		device_reset_o)
		else $error("programming exit unlike power-on");

	AST_START_DELAY: assert property (@(posedge clk_sys_i)
		disable iff (!reset_n_i)
		s_release_low |-> ##1 device_reset_o [*5] ##1 device_reset_o [*5]
		##1 !device_reset_o)
		else $error("start delay after pin release wrong");

	AST_IRQ_VECTOR: assert property (@(posedge clk_sys_i)
		disable iff (!reset_n_i)
		s_irq_wake |=> s_vector_jump)
		else $error("interrupt wake vector sequence wrong");

	AST_FLAGS_HOLD: assert property (@(posedge clk_sys_i)
		disable iff (!reset_n_i)
		(!wr_reset_cause_reg && !soft_rst && !master_clear_pin_start && !brown_evt &&
		!prog_exit) |=> (reset_cause_reg == $past(reset_cause_reg)))
		else $error("cause flags changed with no cause");

endmodule // rsc_reset_ctrl

// [pkg/rsc_regs.svh]
// Register map, field positions, reset values and timing counts
`ifndef RSC_REGS_SVH
`define RSC_REGS_SVH

`define RSC_ADDR_W          2
`define RSC_DATA_W          8
`define RSC_PC_W            15

`define RSC_ADDR_BROWNOUT_CONTROL     2'h0
`define RSC_ADDR_RESET_CAUSE_REG       2'h1
`define RSC_ADDR_STATUS     2'h2

`define RSC_BROWNOUT_CONTROL_SWEN     7
`define RSC_BROWNOUT_CONTROL_FS       6
`define RSC_BROWNOUT_CONTROL_RDY      0
`define RSC_BROWNOUT_CONTROL_SWEN_RST 1'b1
`define RSC_BROWNOUT_CONTROL_FS_RST   1'b0

`define RSC_RESET_CAUSE_REG_OVF        7
`define RSC_RESET_CAUSE_REG_UNF        6
`define RSC_RESET_CAUSE_REG_WDT        4
`define RSC_RESET_CAUSE_REG_PIN        3
`define RSC_RESET_CAUSE_REG_INSTR      2
`define RSC_RESET_CAUSE_REG_POR        1
`define RSC_RESET_CAUSE_REG_BOR        0
`define RSC_RESET_CAUSE_REG_MASK       8'hDF
`define RSC_RESET_CAUSE_REG_POR_VAL    8'h1C

`define RSC_STATUS_TO       4
`define RSC_STATUS_PD       3

`define RSC_MODE_OFF        2'h0
`define RSC_MODE_SW         2'h1
`define RSC_MODE_NOSLEEP    2'h2
`define RSC_MODE_ON         2'h3

`define RSC_VEC_RESET       15'h0000
`define RSC_VEC_IRQ         15'h0004

`define RSC_CLK_PERIOD_NS   10
`define RSC_POWERUP_TIMER_TIME_MS    64
`define RSC_POWERUP_TIMER_CYC  ((`RSC_POWERUP_TIMER_TIME_MS * 1000000) / `RSC_CLK_PERIOD_NS)
`define RSC_START_DLY_CYC   10
`define RSC_FILT_CYC        3'h4
`define RSC_CNT_W           23

`endif

// [pkg/rsc_pkg.sv]
// Types shared by the reset controller
package rsc_pkg;
	typedef enum logic [2:0] {
		ST_HOLD,
		ST_POWERUP_TIMER,
		ST_MASTER_CLEAR_PIN_WAIT,
		ST_START_DLY,
		ST_RUN
	} rsc_state_t;
endpackage

// [test/rsc_far_model.sv]
// Far-side model: reset pin with pull-up and brown-out circuit readiness
`timescale 1ns/10ps
module rsc_far_model #(
	parameter int RDY_DLY = 5
) (
	input  wire logic clk_sys_i,
	input  wire logic hold_low_i,
	input  wire logic pullup_i,
	input  wire logic pin_oe_i,
	input  wire logic pin_out_i,
	input  wire logic detect_en_i,
	output logic      pin_o,
	output logic      ready_o
);
	int   rdy_cnt = 0;
	logic float_lvl = 1'h0;
	// A floating pin is never trusted to hold a level
	always @(posedge clk_sys_i) float_lvl <= ~float_lvl;
	assign pin_o = pin_oe_i ? pin_out_i : hold_low_i ? 1'h0 :
		pullup_i ? 1'h1 : float_lvl;
	// The circuit needs settling time after every enable
	always @(posedge clk_sys_i) begin
		if (!detect_en_i)
			rdy_cnt <= 0;
		else if (rdy_cnt < RDY_DLY)
			rdy_cnt <= rdy_cnt + 1;
	end
	assign ready_o = (rdy_cnt == RDY_DLY);
endmodule // rsc_far_model

// [test/rsc_reset_ctrl_tb.sv]
// Self-checking bench for the reset controller
`timescale 1ns/10ps
module rsc_reset_ctrl_tb;
	localparam int POWERUP_TIMER = 20;
	logic clk_sys_i = 1'h0, reset_n_i = 1'h0, reg_wr_i = 1'h0;
	logic reg_rd_i = 1'h0, hold_low = 1'h0, pullup_sw_i = 1'h0;
	logic [1:0] reg_addr_i = 2'h0, brownout_mode_cfg_i = 2'h3;
	logic [7:0] reg_wdata_i = 8'h00, reg_rdata_o;
	logic low_power_brownout_fuse_i = 1'h1, stack_reset_enable_i = 1'h1;
	logic master_clear_pin_enable_i = 1'h1, powerup_timer_enable_n_i = 1'h0;
	logic low_voltage_programming_i = 1'h0, sleep_i = 1'h0;
	logic global_irq_enable_i = 1'h0;
	logic [4:0] evs = 5'h00;
	logic [2:0] pwr = 3'h0;
	logic [14:0] pc_i = 15'h0000, pc_value_o;
	logic [31:0] seed = 32'h62, d;
	logic master_clear_pin_o, master_clear_pin_oe_o, gp_input_o;
	logic weak_pullup_en_o, device_reset_o, brownout_detect_en_o;
	logic bandgap_force_on_o, pc_load_o, push_return_o;
	wire brownout_ready_i, master_clear_pin_i, irq_wake_i;
	wire watchdog_timeout_i, reset_instr_i, stack_overflow_i;
	wire stack_underflow_i, brownout_low_i, lp_brownout_low_i, prog_mode_i;
	int failures = 0, compares = 0, cyc = 0, reset_cause_reg, stat, n;
	int am[5] = '{8'hFF, 8'hEF, 8'hFB, 8'hFF, 8'hFF};
	int om[5] = '{8'h00, 8'h00, 8'h00, 8'h80, 8'h40};
	assign {stack_underflow_i, stack_overflow_i, reset_instr_i} = evs[4:2];
	assign {watchdog_timeout_i, irq_wake_i} = evs[1:0];
	assign {prog_mode_i, lp_brownout_low_i, brownout_low_i} = pwr;

	rsc_reset_ctrl #(.POWERUP_TIMER_CYCLES(POWERUP_TIMER)) u_rsc_reset_ctrl (
		.clk_sys_i, .reset_n_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i,
		.reg_rd_i, .reg_rdata_o, .brownout_mode_cfg_i,
		.low_power_brownout_fuse_i, .master_clear_pin_enable_i,
		.low_voltage_programming_i, .powerup_timer_enable_n_i,
		.stack_reset_enable_i, .brownout_ready_i, .brownout_low_i,
		.lp_brownout_low_i, .master_clear_pin_i, .pullup_sw_i,
		.master_clear_pin_o, .master_clear_pin_oe_o, .gp_input_o,
		.weak_pullup_en_o, .sleep_i, .watchdog_timeout_i, .reset_instr_i,
		.stack_overflow_i, .stack_underflow_i, .prog_mode_i, .irq_wake_i,
		.global_irq_enable_i, .pc_i, .device_reset_o, .brownout_detect_en_o,
		.bandgap_force_on_o, .pc_load_o, .pc_value_o, .push_return_o
	);
	rsc_far_model u_rsc_far_model (
		.clk_sys_i, .hold_low_i(hold_low), .pullup_i(weak_pullup_en_o),
		.pin_oe_i(master_clear_pin_oe_o), .pin_out_i(master_clear_pin_o),
		.detect_en_i(brownout_detect_en_o), .pin_o(master_clear_pin_i),
		.ready_o(brownout_ready_i)
	);

	initial forever #5 clk_sys_i = ~clk_sys_i;

	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction

	task automatic give_verdict();
		$display("compares %0d failures %0d", compares, failures);
		if (failures == 0 && compares > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	always @(posedge clk_sys_i) begin
		cyc <= cyc + 1;
		if (cyc == 30000) begin
			failures++;
			$display("[FAIL] %0t run did not finish", $time);
			give_verdict();
		end
	end

	task automatic ckv(input logic [14:0] g, input logic [14:0] e);
		compares++;
		if (g !== e) begin
			failures++;
			$display("[FAIL] %0t port %h expected %h", $time, g, e);
		end
	endtask

	task automatic ckr(input logic [1:0] a, input logic [7:0] e);
		@(posedge clk_sys_i);
		reg_rd_i <= 1'h1;
		reg_addr_i <= a;
		@(posedge clk_sys_i);
		reg_rd_i <= 1'h0;
		#1;
		compares++;
		if (reg_rdata_o !== e) begin
			failures++;
			$display("[FAIL] %0t reg %0d read %h expected %h", $time, a,
				reg_rdata_o, e);
		end
	endtask

	task automatic wr(input logic [1:0] a, input logic [7:0] v);
		@(posedge clk_sys_i);
		reg_wr_i <= 1'h1;
		reg_addr_i <= a;
		reg_wdata_i <= v;
		@(posedge clk_sys_i);
		reg_wr_i <= 1'h0;
	endtask

	task automatic ev(input int k);
		@(posedge clk_sys_i);
		evs <= 5'h01 << k;
		@(posedge clk_sys_i);
		evs <= 5'h00;
		#1;
	endtask

	task automatic press(input int len);
		@(posedge clk_sys_i);
		hold_low <= 1'h1;
		repeat (len) @(posedge clk_sys_i);
		hold_low <= 1'h0;
		#1;
	endtask

	// Leaving reset must come with a load of the reset vector
	task automatic wrun();
		n = 0;
		while (device_reset_o !== 1'h0 && n < 300) begin
			@(posedge clk_sys_i);
			#1;
			n++;
		end
		ckv(pc_load_o, 15'h1);
		ckv(pc_value_o, 15'h0000);
		ckv(master_clear_pin_oe_o, 15'h0);
	endtask

	// Software restores the flags with a random pattern
	task automatic restore();
		d = rnd();
		wr(1, d[7:0]);
		reset_cause_reg = d[7:0] & 8'hDF;
	endtask

	task automatic done(input string s);
		$display("test %s done", s);
	endtask

	initial begin
		repeat (16) @(posedge clk_sys_i);
		reset_n_i <= 1'h1;
		reset_cause_reg = 8'h1C;
		stat = 8'h18;
		ckr(1, 8'(reset_cause_reg));
		ckr(2, 8'(stat));
		wrun();
		ckv(15'(n + 4 > POWERUP_TIMER), 15'h1);
		wr(3, 8'hFF);
		ckr(3, 8'h00);
		done("power_on");
		for (int m = 0; m < 4; m++) begin
			brownout_mode_cfg_i <= 2'(m);
			for (int b = 0; b < 4; b++) begin
				wr(0, {2'(b), 6'h3F});
				repeat (2) @(posedge clk_sys_i);
				#1;
				ckv(brownout_detect_en_o, 15'(m > 1 || m == 1 && b > 1));
				ckv(bandgap_force_on_o, 15'((m == 1 || m == 2) && b[0]));
			end
			repeat (8) @(posedge clk_sys_i);
			ckr(0, {2'h3, 5'h00, m != 0});
		end
		done("brownout_control");
		for (int k = 1; k < 5; k++) begin
			restore();
			ev(k);
			ckv(device_reset_o, 15'h1);
			wrun();
			reset_cause_reg = reset_cause_reg & am[k] | om[k];
			if (k == 1)
				stat = stat & 8'hEF;
			ckr(1, 8'(reset_cause_reg));
			ckr(2, 8'(stat));
		end
		stack_reset_enable_i <= 1'h0;
		ev(3);
		ckv(device_reset_o, 15'h0);
		ckr(1, 8'(reset_cause_reg));
		stack_reset_enable_i <= 1'h1;
		done("soft_resets");
		press(3);
		repeat (4) @(posedge clk_sys_i);
		#1;
		ckv(device_reset_o, 15'h0);
		press(8);
		ckv(device_reset_o, 15'h1);
		wrun();
		ckv(15'(n >= 10), 15'h1);
		reset_cause_reg = reset_cause_reg & 8'hF7;
		ckr(1, 8'(reset_cause_reg));
		ckr(2, 8'(stat));
		sleep_i <= 1'h1;
		press(8);
		sleep_i <= 1'h0;
		wrun();
		stat = stat & 8'hF7 | 8'h10;
		ckr(2, 8'(stat));
		done("pin");
		global_irq_enable_i <= 1'h1;
		sleep_i <= 1'h1;
		pc_i <= 15'(rnd());
		ev(0);
		ckv(pc_load_o, 15'h1);
		ckv(pc_value_o, pc_i + 15'h0001);
		@(posedge clk_sys_i);
		#1;
		ckv(pc_value_o, 15'h0004);
		ckv(push_return_o, 15'h1);
		ckr(2, 8'(stat));
		pc_i <= 15'(rnd());
		ev(1);
		ckv(device_reset_o, 15'h0);
		ckv(pc_value_o, pc_i + 15'h0001);
		stat = stat & 8'hE7;
		ckr(2, 8'(stat));
		sleep_i <= 1'h0;
		done("wake");
		pwr <= 3'h2;
		repeat (3) @(posedge clk_sys_i);
		pwr <= 3'h0;
		#1;
		ckv(device_reset_o, 15'h0);
		low_power_brownout_fuse_i <= 1'h0;
		for (int s = 0; s < 3; s++) begin
			restore();
			pwr <= 3'h1 << s;
			repeat (3) @(posedge clk_sys_i);
			pwr <= 3'h0;
			wrun();
			ckv(15'(n >= POWERUP_TIMER), 15'h1);
			reset_cause_reg = s == 2 ? 8'h1C : reset_cause_reg & 8'h12 | 8'h0C;
			stat = 8'h18;
			ckr(1, 8'(reset_cause_reg));
			ckr(2, 8'(stat));
		end
		done("power_events");
		master_clear_pin_enable_i <= 1'h0;
		hold_low <= 1'h1;
		repeat (8) @(posedge clk_sys_i);
		#1;
		ckv(device_reset_o, 15'h0);
		ckv(gp_input_o, 15'h0);
		ckv(weak_pullup_en_o, 15'h0);
		pullup_sw_i <= 1'h1;
		hold_low <= 1'h0;
		repeat (2) @(posedge clk_sys_i);
		#1;
		ckv(gp_input_o, 15'h1);
		ckv(weak_pullup_en_o, 15'h1);
		low_voltage_programming_i <= 1'h1;
		pullup_sw_i <= 1'h0;
		press(8);
		ckv(device_reset_o, 15'h1);
		wrun();
		ckv(weak_pullup_en_o, 15'h1);
		done("pin_config");
		give_verdict();
	end
endmodule // rsc_reset_ctrl_tb
